// ---- src/dcmt_pkg.sv ----
// Package: register map, field layout, reset values and prescaler taps of the dual compare match timer
package dcmt_pkg;
   // Register byte offsets on APB (word aligned)
   localparam logic [7:0] OFF_RUN       = 8'h00;
   localparam logic [7:0] OFF_CSR0      = 8'h04;
   localparam logic [7:0] OFF_CNT0      = 8'h08;
   localparam logic [7:0] OFF_PER0      = 8'h0c;
   localparam logic [7:0] OFF_CSR1      = 8'h10;
   localparam logic [7:0] OFF_CNT1      = 8'h14;
   localparam logic [7:0] OFF_PER1      = 8'h18;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h1c;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'h20;
   localparam logic [7:0] OFF_XFER_CTRL = 8'h24;
   // Control/status fields
   localparam int CSR_FLAG_BIT = 7;
   localparam int CSR_IE_BIT   = 6;
   localparam int CSR_CKS_HI   = 1;
   localparam int CSR_CKS_LO   = 0;
   // Transfer-controller clear control: bit n is the disable-select of channel n
   localparam int XFER_DIS_BIT0 = 0;
   // Reset values
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] PER_RESET = 16'hffff;
   // Prescaler tap divisors
   localparam int DIV_CODE0 = 8;
   localparam int DIV_CODE1 = 32;
   localparam int DIV_CODE2 = 128;
   localparam int DIV_CODE3 = 512;
   localparam int PRESCALE_W = 9;
   localparam logic [1:0] CKS_DIV8   = 2'h0;
   localparam logic [1:0] CKS_DIV32  = 2'h1;
   localparam logic [1:0] CKS_DIV128 = 2'h2;
   localparam logic [1:0] CKS_DIV512 = 2'h3;
endpackage

// ---- src/dcmt_timer.sv ----
// Dual-channel 16-bit compare match timer with APB register access
//
// Behaviour
// - Two-bit clock select picks divide by 8, 32, 128 or 512 tap.
// - With run bit set, counter increments once per selected tap pulse.
// - Each counter is a 16-bit readable/writable up-counter reset to 0x0000.
// - Each period register is 16-bit read/write, reset to 0xffff.
// - On match counter clears to zero, flag sets, counting resumes.
// - Channel interrupt asserted only while flag and enable are both one.
// - Each channel drives its own interrupt request line.
// - Interrupt request can trigger transfer controller; channel priority fixed.
// - Match fires at the increment leaving the matching value.
// - Flag cleared by read-one-then-write-zero, or transfer-controller clear signal.
// - Writing one to the flag does nothing.
// - Match during counter write: clear wins, written value discarded.
// - Increment during word write: write loads, increment dropped.
// - Increment during byte write: byte loads, other byte kept, no increment.
// - Shared run register, bit 0 channel 0, bit 1 channel 1.
// - Flag at bit 7, enable at bit 6, other high bits zero.
// - Transfer clear acts only when disable-select is zero.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dcmt_timer
   import dcmt_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RSTN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [1:0]  XFER_DONE,
   output logic      [1:0]  MATCH_IRQ,
   output logic             IRQ
);

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler

   logic [PRESCALE_W-1:0] prescale;
   logic [PRESCALE_W-1:0] next_prescale;
   logic [3:0]            tap;

   always_comb begin
      next_prescale = prescale + 9'h001;
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         prescale <= '0;
      end else begin
         prescale <= next_prescale;
      end
   end

   // Single-cycle enables, one per tap, instead of derived clocks
   always_comb begin
      tap[0] = (prescale[2:0] == 3'h7);
      tap[1] = (prescale[4:0] == 5'h1f);
      tap[2] = (prescale[6:0] == 7'h7f);
      tap[3] = (prescale[8:0] == 9'h1ff);
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   logic wr_en;
   logic rd_en;
   logic addr_ok;

   always_comb begin
      wr_en   = PSEL && PENABLE && PWRITE;
      rd_en   = PSEL && PENABLE && !PWRITE;
      addr_ok = (PADDR <= OFF_XFER_CTRL) && (PADDR[1:0] == 2'h0);
   end

   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [1:0]  run;
   logic [1:0]  next_run;
   logic [1:0]  cks [2];
   logic [1:0]  next_cks [2];
   logic [1:0]  ie;
   logic [1:0]  next_ie;
   logic [1:0]  flag;
   logic [1:0]  next_flag;
   logic [1:0]  flag_seen;
   logic [1:0]  next_flag_seen;
   logic [15:0] cnt [2];
   logic [15:0] next_cnt [2];
   logic [15:0] per [2];
   logic [15:0] next_per [2];
   logic [1:0]  stat;
   logic [1:0]  next_stat;
   logic [1:0]  mask;
   logic [1:0]  next_mask;
   logic [1:0]  xfer_dis;
   logic [1:0]  next_xfer_dis;
   logic [1:0]  inc;
   logic [1:0]  match;

   always_comb begin
      logic [7:0]  a_csr;
      logic [7:0]  a_cnt;
      logic [7:0]  a_per;
      logic [15:0] wv;
      a_csr = 8'h00;
      a_cnt = 8'h00;
      a_per = 8'h00;
      wv    = 16'h0000;
      next_run      = run;
      next_ie       = ie;
      next_flag     = flag;
      next_flag_seen = flag_seen;
      next_mask     = mask;
      next_xfer_dis = xfer_dis;
      next_stat     = stat;
      if (wr_en && PADDR == OFF_RUN && PSTRB[0]) begin
         next_run = PWDATA[1:0];
      end
      if (wr_en && PADDR == OFF_IRQ_MASK && PSTRB[0]) begin
         next_mask = PWDATA[1:0];
      end
      if (wr_en && PADDR == OFF_XFER_CTRL && PSTRB[0]) begin
         next_xfer_dis = PWDATA[XFER_DIS_BIT0 +: 2];
      end
      if (wr_en && PADDR == OFF_IRQ_STAT && PSTRB[0]) begin
         next_stat = stat & ~PWDATA[1:0];
      end
      for (int c = 0; c < 2; c++) begin
         a_csr = c[0] ? OFF_CSR1 : OFF_CSR0;
         a_cnt = c[0] ? OFF_CNT1 : OFF_CNT0;
         a_per = c[0] ? OFF_PER1 : OFF_PER0;
         next_cks[c] = cks[c];
         next_per[c] = per[c];
         next_cnt[c] = cnt[c];
         // Tap selection per channel
         case (cks[c])
            CKS_DIV8:   inc[c] = tap[0];
            CKS_DIV32:  inc[c] = tap[1];
            CKS_DIV128: inc[c] = tap[2];
            CKS_DIV512: inc[c] = tap[3];
            default:    inc[c] = 1'b0;
         endcase
         inc[c] = inc[c] && run[c];
         // Match fires on the increment leaving the period value
         match[c] = inc[c] && (cnt[c] == per[c]);
         if (rd_en && PADDR == a_csr && flag[c]) begin
            next_flag_seen[c] = 1'b1;
         end
         if (wr_en && PADDR == a_csr && PSTRB[0]) begin
            next_ie[c]  = PWDATA[CSR_IE_BIT];
            next_cks[c] = PWDATA[CSR_CKS_HI:CSR_CKS_LO];
            // Only a zero written after seeing one clears; a one is ignored
            if (!PWDATA[CSR_FLAG_BIT] && flag_seen[c]) begin
               next_flag[c]      = 1'b0;
               next_flag_seen[c] = 1'b0;
            end
         end
         if (XFER_DONE[c] && !xfer_dis[c]) begin
            next_flag[c]      = 1'b0;
            next_flag_seen[c] = 1'b0;
         end
         if (wr_en && PADDR == a_per) begin
            if (PSTRB[0]) next_per[c][7:0]  = PWDATA[7:0];
            if (PSTRB[1]) next_per[c][15:8] = PWDATA[15:8];
         end
         if (inc[c]) begin
            next_cnt[c] = cnt[c] + 16'h0001;
         end
         // Write replaces the increment; untouched byte keeps its old value
         if (wr_en && PADDR == a_cnt && (PSTRB[1:0] != 2'h0)) begin
            wv = cnt[c];
            if (PSTRB[0]) wv[7:0]  = PWDATA[7:0];
            if (PSTRB[1]) wv[15:8] = PWDATA[15:8];
            next_cnt[c] = wv;
         end
         // Set wins over any clear in the same cycle
         if (match[c]) begin
            next_cnt[c]  = CNT_RESET;
            next_flag[c] = 1'b1;
            next_stat[c] = 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         run       <= 2'h0;
         ie        <= 2'h0;
         flag      <= 2'h0;
         flag_seen <= 2'h0;
         stat      <= 2'h0;
         mask      <= 2'h0;
         xfer_dis  <= 2'h0;
         for (int c = 0; c < 2; c++) begin
            cks[c] <= 2'h0;
            cnt[c] <= CNT_RESET;
            per[c] <= PER_RESET;
         end
      end else begin
         run       <= next_run;
         ie        <= next_ie;
         flag      <= next_flag;
         flag_seen <= next_flag_seen;
         stat      <= next_stat;
         mask      <= next_mask;
         xfer_dis  <= next_xfer_dis;
         for (int c = 0; c < 2; c++) begin
            cks[c] <= next_cks[c];
            cnt[c] <= next_cnt[c];
            per[c] <= next_per[c];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts

   // Separate lines per channel; the transfer controller also listens here
   // and arbitrates channel 0 over channel 1 itself
   assign MATCH_IRQ = flag & ie;
   assign IRQ       = |(stat & mask);

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   logic [31:0] rdata;

   always_comb begin
      rdata = 32'h0000_0000;
      case (PADDR)
         OFF_RUN:       rdata[1:0] = run;
         OFF_CSR0:      rdata = {24'h0, flag[0], ie[0], 4'h0, cks[0]};
         OFF_CSR1:      rdata = {24'h0, flag[1], ie[1], 4'h0, cks[1]};
         OFF_CNT0:      rdata[15:0] = cnt[0];
         OFF_CNT1:      rdata[15:0] = cnt[1];
         OFF_PER0:      rdata[15:0] = per[0];
         OFF_PER1:      rdata[15:0] = per[1];
         OFF_IRQ_STAT:  rdata[1:0] = stat;
         OFF_IRQ_MASK:  rdata[1:0] = mask;
         OFF_XFER_CTRL: rdata[1:0] = xfer_dis;
         default:       rdata = 32'h0000_0000;
      endcase
   end

   // Read data registered during setup so it is stable in the access phase
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         PRDATA <= 32'h0000_0000;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         PRDATA <= rdata;
      end
   end

endmodule // dcmt_timer
`default_nettype wire

// ---- test/dcmt_chk.sv ----
// Checker of the timer's register port and interrupt outputs
`timescale 1ns/1ps
`default_nettype none
module dcmt_chk
   import dcmt_pkg::*;
(
   input wire logic        MCLK,
   input wire logic        RSTN,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0]  PSTRB,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [1:0]  XFER_DONE,
   input wire logic [1:0]  MATCH_IRQ,
   input wire logic        IRQ
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   logic wr_acc;
   logic rd_set;
   assign wr_acc = PSEL & PENABLE & PWRITE & PREADY;
   assign rd_set = PSEL & ~PENABLE & ~PWRITE;
   ////////////////////////////////////////////////////////////////
   property p_ie0; wr_acc && PADDR == OFF_CSR0 && PSTRB[0] && !PWDATA[6] |=> !MATCH_IRQ[0]; endproperty
   a_ie0: assert property (p_ie0) else $error("ch0 request with enable off");
   property p_ie1; wr_acc && PADDR == OFF_CSR1 && PSTRB[0] && !PWDATA[6] |=> !MATCH_IRQ[1]; endproperty
   a_ie1: assert property (p_ie1) else $error("ch1 request with enable off");
   property p_csr; rd_set && (PADDR == OFF_CSR0 || PADDR == OFF_CSR1) |=> PRDATA[15:8] == 0 && PRDATA[5:2] == 0;
   endproperty
   a_csr: assert property (p_csr) else $error("status reserved bits set");
   property p_run; rd_set && PADDR == OFF_RUN |=> PRDATA[31:2] == 0; endproperty
   a_run: assert property (p_run) else $error("run reserved bits set");
   property p_w16; rd_set && (PADDR == OFF_CNT0 || PADDR == OFF_PER1) |=> PRDATA[31:16] == 0; endproperty
   a_w16: assert property (p_w16) else $error("16-bit register too wide");
   property p_mask; wr_acc && PADDR == OFF_IRQ_MASK && PSTRB[0] && PWDATA[1:0] == 0 |=> !IRQ[*2]; endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt high");
   property p_hold; !rd_set |=> $stable(PRDATA); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_unm; PSEL && PENABLE && PADDR > OFF_XFER_CTRL |-> PSLVERR; endproperty
   a_unm: assert property (p_unm) else $error("unmapped access not flagged");
endmodule // dcmt_chk
bind dcmt_timer dcmt_chk dcmt_chk_inst (.MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .XFER_DONE(XFER_DONE), .MATCH_IRQ(MATCH_IRQ), .IRQ(IRQ));
`default_nettype wire

// ---- test/dual_compare_match_timer_tb.sv ----
// Self-checking testbench of the dual compare match timer
`timescale 1ns/1ps
`default_nettype none
module dual_compare_match_timer_tb
   import dcmt_pkg::*;
;
   logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv, r2;
   logic [3:0]  pstrb = 4'h3;
   logic [1:0]  xfer_done = 2'h0, match_irq;
   int          fail_count = 0, checks = 0, cyc = 0;
   // Rows: address, expected value after reset
   logic [39:0] rows [9] = '{{OFF_RUN, 32'h0}, {OFF_CSR0, 32'h0}, {OFF_CNT0, 32'h0}, {OFF_PER0, 32'hffff},
      {OFF_CSR1, 32'h0}, {OFF_CNT1, 32'h0}, {OFF_PER1, 32'hffff}, {OFF_XFER_CTRL, 32'h0}, {8'h28, 32'h0}};
   dcmt_timer dcmt_timer_inst (.MCLK(mclk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .XFER_DONE(xfer_done), .MATCH_IRQ(match_irq), .IRQ(irq));
   always #50 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Ceiling well above the clock-select sweep, the longest part
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // One APB transfer; an idle edge follows so strobes never toggle twice at once
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1, a, d, r2);
   endtask
   task automatic wt(input int c);
      for (int i = 0; i < 400 && match_irq[c] !== 1'b1; i++) @(posedge mclk);
   endtask
   task automatic pulse(input logic [1:0] v);
      xfer_done <= v;
      @(posedge mclk);
      xfer_done <= 2'h0;
      @(posedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge mclk);
      rstn <= 1;
      @(posedge mclk);
      foreach (rows[i]) begin
         xfer(0, rows[i][39:32], 0, rv);
         chk(rv, rows[i][31:0]);
      end
      $display("end: reset values");
      wr(OFF_PER0, 32'h3);
      wr(OFF_CSR0, 32'h40);
      wr(OFF_IRQ_MASK, 32'h0);
      wr(OFF_RUN, 32'h1);
      wt(0);
      wr(OFF_RUN, 32'h0);
      chk(32'(match_irq), 32'h1);
      xfer(0, OFF_CNT0, 0, rv);
      chk(32'(rv <= 3), 32'h1);
      repeat (40) @(posedge mclk);
      xfer(0, OFF_CNT0, 0, r2);
      chk(r2, rv);
      chk(32'(irq), 32'h0);
      wr(OFF_IRQ_MASK, 32'h1);
      chk(32'(irq), 32'h1);
      wr(OFF_IRQ_STAT, 32'h1);
      chk(32'(irq), 32'h0);
      wr(OFF_CSR0, 32'h40);
      chk(32'(match_irq), 32'h1);
      xfer(0, OFF_CSR0, 0, rv);
      chk(rv, 32'hc0);
      wr(OFF_CSR0, 32'h40);
      chk(32'(match_irq), 32'h0);
      wr(OFF_CSR0, 32'hc0);
      chk(32'(match_irq), 32'h0);
      $display("end: match and flag");
      wr(OFF_PER1, 32'h1);
      wr(OFF_CSR1, 32'h40);
      wr(OFF_XFER_CTRL, 32'h2);
      wr(OFF_RUN, 32'h2);
      wt(1);
      wr(OFF_RUN, 32'h0);
      chk(32'(match_irq), 32'h2);
      pulse(2'h2);
      chk(32'(match_irq), 32'h2);
      wr(OFF_XFER_CTRL, 32'h0);
      pulse(2'h2);
      chk(32'(match_irq), 32'h0);
      wr(OFF_CSR1, 32'h0);
      $display("end: transfer clear");
      wr(OFF_PER0, 32'hffff);
      for (int k = 0; k < 4; k++) begin
         wr(OFF_CNT0, 32'h0);
         wr(OFF_CSR0, 32'(k));
         wr(OFF_RUN, 32'h1);
         repeat (2048) @(posedge mclk);
         wr(OFF_RUN, 32'h0);
         xfer(0, OFF_CNT0, 0, rv);
         chk(32'(rv >= (2048 >> (3 + 2 * k)) && rv <= (2048 >> (3 + 2 * k)) + 1), 32'h1);
      end
      $display("end: clock select");
      rstn <= 0;
      repeat (2) @(posedge mclk);
      rstn <= 1;
      chk(32'({irq, match_irq}), 32'h0);
      // Reset restarts the prescaler, so divide-by-8 taps land on edges 8, 16 and 24 from here
      wr(OFF_CSR0, 32'h0);
      wr(OFF_RUN, 32'h1);
      wr(OFF_CNT0, 32'h0100);
      xfer(0, OFF_CNT0, 0, rv);
      chk(rv, 32'h0100);
      pstrb <= 4'h1;
      repeat (2) @(posedge mclk);
      wr(OFF_CNT0, 32'h0022);
      pstrb <= 4'h3;
      wr(OFF_PER0, 32'h0122);
      repeat (2) @(posedge mclk);
      wr(OFF_CNT0, 32'h0055);
      xfer(0, OFF_CNT0, 0, rv);
      chk(rv, 32'h0);
      xfer(0, OFF_CSR0, 0, rv);
      chk(rv, 32'h80);
      $display("end: write contention");
      conclude();
   end
endmodule // dual_compare_match_timer_tb
`default_nettype wire
